// ==== gpio_regs.vh ====
// register indices, field layouts, reset values and masks of the gpio ports
`ifndef GPIO_REGS_VH
`define GPIO_REGS_VH

// register indices; the byte address is four times the index
`define IDX_CHG_EN_LO 10'h0c0
`define IDX_CHG_EN_HI 10'h0c2
`define IDX_CHG_PU_LO 10'h0c4
`define IDX_CHG_PU_HI 10'h0c6
`define IDX_A_DIR 10'h2c0
`define IDX_A_PIN 10'h2c2
`define IDX_A_LAT 10'h2c4
`define IDX_B_DIR 10'h2c6
`define IDX_B_PIN 10'h2c8
`define IDX_B_LAT 10'h2cb
`define IDX_C_DIR 10'h2cc
`define IDX_C_PIN 10'h2ce
`define IDX_C_LAT 10'h2d0
`define IDX_D_DIR 10'h2d2
`define IDX_D_PIN 10'h2d4
`define IDX_D_LAT 10'h2d6
`define IDX_F_DIR 10'h2de
`define IDX_F_PIN 10'h2e0
`define IDX_F_LAT 10'h2e2
`define IDX_IRQ_STATUS 10'h0f0
`define IDX_IRQ_ENABLE 10'h0f1
`define IDX_IRQ_CLEAR 10'h0f2

// implemented pins per port, packed f,d,c,b,a from the top
`define PORT_MASK_ALL {16'h007f, 16'h030f, 16'he000, 16'h1fff, 16'h0800}
`define DIR_RESET_ALL {16'h007f, 16'h030f, 16'he000, 16'h1fff, 16'h0800}
`define LAT_RESET_ALL 80'h0
`define CHG_RESET 24'h000000

// register kinds within a port
`define KIND_DIR 2'h0
`define KIND_PIN 2'h1
`define KIND_LAT 2'h2

// interrupt status layout and bus response codes
`define IRQ_CHANGE_BIT 0
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ==== gpio_ports.v ====
// gpio ports a, b, c, d and f with input change notification and an axi4-lite register slave
//
// Behaviour
// - any enabled monitored input changing state raises the change interrupt request.
// - change detection keeps working in sleep; a combinational wake request needs no clock.
// - up to 24 monitored inputs, numbered 0 to 23.
// - each monitored input has an interrupt enable bit; only enabled ones count; reset zero.
// - pull-up enables: inputs 0-15 in low register, 16-23 in high bits 7:0.
// - smaller variant implements inputs 0 to 18; missing bits read zero.
// - implemented direction bits reset to one; pin and latch registers reset to zero.
// - port b has pins 12 to 0; bits 15 to 13 read zero.
// - direction one makes an input with driver off; zero drives the latch.
// - pin register reads sampled pins, writes the latch; latch register accesses latch.
// - pins selected as analog inputs read zero through the pin register.
// - a peripheral driving a pin disables the port driver; the pin stays readable.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`include "gpio_regs.vh"

module gpio_ports #(
    parameter CHANGE_COUNT = 24 // monitored inputs, 19 on the small variant
) (
    input wire aclk, // system clock
    input wire aresetn, // synchronous reset, active low
    input wire [31:0] s_axi_awaddr, // write address
    input wire s_axi_awvalid, // write address valid
    output wire s_axi_awready, // write address ready
    input wire [31:0] s_axi_wdata, // write data
    input wire [3:0] s_axi_wstrb, // write byte strobes
    input wire s_axi_wvalid, // write data valid
    output wire s_axi_wready, // write data ready
    output reg [1:0] s_axi_bresp, // write response
    output reg s_axi_bvalid, // write response valid
    input wire s_axi_bready, // write response ready
    input wire [31:0] s_axi_araddr, // read address
    input wire s_axi_arvalid, // read address valid
    output wire s_axi_arready, // read address ready
    output reg [31:0] s_axi_rdata, // read data
    output reg [1:0] s_axi_rresp, // read response
    output reg s_axi_rvalid, // read data valid
    input wire s_axi_rready, // read data ready
    input wire [15:0] port_a_in, // port a pin levels
    output wire [15:0] port_a_out, // port a output data
    output wire [15:0] port_a_oe, // port a output enables
    input wire [15:0] port_b_in, // port b pin levels
    output wire [15:0] port_b_out, // port b output data
    output wire [15:0] port_b_oe, // port b output enables
    input wire [15:0] port_c_in, // port c pin levels
    output wire [15:0] port_c_out, // port c output data
    output wire [15:0] port_c_oe, // port c output enables
    input wire [15:0] port_d_in, // port d pin levels
    output wire [15:0] port_d_out, // port d output data
    output wire [15:0] port_d_oe, // port d output enables
    input wire [15:0] port_f_in, // port f pin levels
    output wire [15:0] port_f_out, // port f output data
    output wire [15:0] port_f_oe, // port f output enables
    input wire [79:0] periph_drive, // peripheral drives pin, packed f,d,c,b,a
    input wire [15:0] analog_b, // port b pins used as analog inputs
    input wire [23:0] change_in, // monitored input pins
    output wire [23:0] pullup_en, // weak pull-up enables
    output wire change_wake, // asynchronous wake request while clocks stop
    output wire irq // level interrupt request
);

// --------------------------------------------------------------------
// constants and state
// --------------------------------------------------------------------
localparam [79:0] PORT_MASK = `PORT_MASK_ALL;
localparam [23:0] CHG_MASK = 24'hffffff >> (24 - CHANGE_COUNT);

reg [79:0] dir_all;
reg [79:0] lat_all;
reg [23:0] chg_en;
reg [23:0] chg_pu;
reg [23:0] chg_prev;
reg [31:0] irq_status;
reg [31:0] irq_enable;
reg [103:0] sync1;
reg [103:0] sync2;
reg [103:0] sync3;
reg [103:0] filt;
reg aw_held;
reg w_held;
reg [9:0] aw_idx;
reg [15:0] w_data;
reg [1:0] w_strb;

wire [103:0] raw_in = {change_in, port_f_in, port_d_in, port_c_in, port_b_in, port_a_in};
wire [79:0] pin_lvl = filt[79:0];
wire [23:0] chg_lvl = filt[103:80];

// --------------------------------------------------------------------
// pin synchroniser
// --------------------------------------------------------------------
// a change is accepted once stages two and three agree, so a stage-two
// glitch never reaches the pin register or the detector
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        sync1 <= 104'h0;
        sync2 <= 104'h0;
        sync3 <= 104'h0;
        filt <= 104'h0;
    end
    else
    begin
        sync1 <= raw_in;
        sync2 <= sync1;
        sync3 <= sync2;
        filt <= (sync2 & sync3) | (filt & (sync2 ^ sync3));
    end
end

// --------------------------------------------------------------------
// change detector and pads
// --------------------------------------------------------------------
wire [23:0] chg_live = chg_en & CHG_MASK;
wire change_evt = |((chg_lvl ^ chg_prev) & chg_live);

// raw pins against the held reference, so a change still wakes with aclk stopped
assign change_wake = |((change_in ^ chg_prev) & chg_live);
assign pullup_en = chg_pu & CHG_MASK;
assign irq = |(irq_status & irq_enable);

wire [79:0] drive = ~dir_all & ~periph_drive & PORT_MASK;
assign port_a_oe = drive[15:0];
assign port_b_oe = drive[31:16];
assign port_c_oe = drive[47:32];
assign port_d_oe = drive[63:48];
assign port_f_oe = drive[79:64];
assign port_a_out = lat_all[15:0];
assign port_b_out = lat_all[31:16];
assign port_c_out = lat_all[47:32];
assign port_d_out = lat_all[63:48];
assign port_f_out = lat_all[79:64];

// pin register view: unimplemented and analog pins read zero
wire [79:0] pin_view = pin_lvl & PORT_MASK & ~{48'h0, analog_b, 16'h0};

// --------------------------------------------------------------------
// address decode
// --------------------------------------------------------------------
// returns {hit, port[2:0], kind[1:0]} for the port registers
function [5:0] port_decode;
    input [9:0] idx;
    begin
        if (idx == `IDX_A_DIR) port_decode = {1'b1, 3'd0, `KIND_DIR};
        else if (idx == `IDX_A_PIN) port_decode = {1'b1, 3'd0, `KIND_PIN};
        else if (idx == `IDX_A_LAT) port_decode = {1'b1, 3'd0, `KIND_LAT};
        else if (idx == `IDX_B_DIR) port_decode = {1'b1, 3'd1, `KIND_DIR};
        else if (idx == `IDX_B_PIN) port_decode = {1'b1, 3'd1, `KIND_PIN};
        else if (idx == `IDX_B_LAT) port_decode = {1'b1, 3'd1, `KIND_LAT};
        else if (idx == `IDX_C_DIR) port_decode = {1'b1, 3'd2, `KIND_DIR};
        else if (idx == `IDX_C_PIN) port_decode = {1'b1, 3'd2, `KIND_PIN};
        else if (idx == `IDX_C_LAT) port_decode = {1'b1, 3'd2, `KIND_LAT};
        else if (idx == `IDX_D_DIR) port_decode = {1'b1, 3'd3, `KIND_DIR};
        else if (idx == `IDX_D_PIN) port_decode = {1'b1, 3'd3, `KIND_PIN};
        else if (idx == `IDX_D_LAT) port_decode = {1'b1, 3'd3, `KIND_LAT};
        else if (idx == `IDX_F_DIR) port_decode = {1'b1, 3'd4, `KIND_DIR};
        else if (idx == `IDX_F_PIN) port_decode = {1'b1, 3'd4, `KIND_PIN};
        else if (idx == `IDX_F_LAT) port_decode = {1'b1, 3'd4, `KIND_LAT};
        else port_decode = 6'h00;
    end
endfunction

function [15:0] merge;
    input [15:0] old;
    input [15:0] data;
    input [1:0] strb;
    begin
        merge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    end
endfunction

// --------------------------------------------------------------------
// write channel
// --------------------------------------------------------------------
assign s_axi_awready = !aw_held && !s_axi_bvalid;
assign s_axi_wready = !w_held && !s_axi_bvalid;

wire do_write = aw_held && w_held && !s_axi_bvalid;
wire [5:0] wdec = port_decode(aw_idx);
wire [6:0] wbase = {wdec[4:2], 4'h0};
wire [15:0] wmask = PORT_MASK[wbase +: 16];
wire w_cn = (aw_idx == `IDX_CHG_EN_LO) || (aw_idx == `IDX_CHG_EN_HI)
    || (aw_idx == `IDX_CHG_PU_LO) || (aw_idx == `IDX_CHG_PU_HI);
wire w_irq = (aw_idx == `IDX_IRQ_ENABLE) || (aw_idx == `IDX_IRQ_CLEAR);
wire clr_change = do_write && (aw_idx == `IDX_IRQ_CLEAR) && w_strb[0]
    && w_data[`IRQ_CHANGE_BIT];

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        aw_idx <= 10'h0;
        w_data <= 16'h0;
        w_strb <= 2'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `RESP_OKAY;
        dir_all <= `DIR_RESET_ALL;
        lat_all <= `LAT_RESET_ALL;
        chg_en <= `CHG_RESET;
        chg_pu <= `CHG_RESET;
        irq_enable <= 32'h0;
    end
    else
    begin
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held <= 1'b1;
            aw_idx <= s_axi_awaddr[11:2];
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata[15:0];
            w_strb <= s_axi_wstrb[1:0];
        end
        if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
        if (do_write)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wdec[5] || w_cn || w_irq) ? `RESP_OKAY : `RESP_SLVERR;
            if (wdec[5] && wdec[1:0] == `KIND_DIR)
                dir_all[wbase +: 16] <= merge(dir_all[wbase +: 16], w_data, w_strb) & wmask;
            if (wdec[5] && wdec[1:0] != `KIND_DIR)
                lat_all[wbase +: 16] <= merge(lat_all[wbase +: 16], w_data, w_strb) & wmask;
            if (aw_idx == `IDX_CHG_EN_LO)
                chg_en[15:0] <= merge(chg_en[15:0], w_data, w_strb);
            if (aw_idx == `IDX_CHG_EN_HI && w_strb[0])
                chg_en[23:16] <= w_data[7:0];
            if (aw_idx == `IDX_CHG_PU_LO)
                chg_pu[15:0] <= merge(chg_pu[15:0], w_data, w_strb);
            if (aw_idx == `IDX_CHG_PU_HI && w_strb[0])
                chg_pu[23:16] <= w_data[7:0];
            if (aw_idx == `IDX_IRQ_ENABLE && w_strb[0])
                irq_enable <= {31'h0, w_data[`IRQ_CHANGE_BIT]};
        end
    end
end

// --------------------------------------------------------------------
// change capture and sticky status
// --------------------------------------------------------------------
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        chg_prev <= 24'h0;
        irq_status <= 32'h0;
    end
    else
    begin
        chg_prev <= chg_lvl;
        // a change in the same cycle as the clear keeps the bit set
        if (change_evt)
            irq_status[`IRQ_CHANGE_BIT] <= 1'b1;
        else if (clr_change)
            irq_status[`IRQ_CHANGE_BIT] <= 1'b0;
    end
end

// --------------------------------------------------------------------
// read channel
// --------------------------------------------------------------------
assign s_axi_arready = !s_axi_rvalid;

wire [9:0] r_idx = s_axi_araddr[11:2];
wire [5:0] rdec = port_decode(r_idx);
wire [6:0] rbase = {rdec[4:2], 4'h0};
reg [15:0] r_val;
reg r_hit;

always @*
begin
    r_hit = 1'b1;
    r_val = 16'h0;
    if (rdec[5] && rdec[1:0] == `KIND_DIR)
        r_val = dir_all[rbase +: 16];
    else if (rdec[5] && rdec[1:0] == `KIND_PIN)
        r_val = pin_view[rbase +: 16];
    else if (rdec[5])
        r_val = lat_all[rbase +: 16];
    else if (r_idx == `IDX_CHG_EN_LO)
        r_val = chg_live[15:0];
    else if (r_idx == `IDX_CHG_EN_HI)
        r_val = {8'h00, chg_live[23:16]};
    else if (r_idx == `IDX_CHG_PU_LO)
        r_val = pullup_en[15:0];
    else if (r_idx == `IDX_CHG_PU_HI)
        r_val = {8'h00, pullup_en[23:16]};
    else if (r_idx == `IDX_IRQ_STATUS)
        r_val = irq_status[15:0];
    else if (r_idx == `IDX_IRQ_ENABLE)
        r_val = irq_enable[15:0];
    else if (r_idx == `IDX_IRQ_CLEAR)
        r_val = 16'h0;
    else
        r_hit = 1'b0;
end

// pin data reaches the pin register four cycles after the pin moves, so a direction
// write followed directly by a pin read may show the old level
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {16'h0, r_val};
        s_axi_rresp <= r_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
end

endmodule // gpio_ports

// ==== pin_board.sv ====
// board side of port b: each pin shows the port driver or the external source
`timescale 1ns/1ps
module pin_board (
    input wire [15:0] out, // port output data
    input wire [15:0] oe, // port drives pin
    input wire [15:0] ext, // external source level
    output wire [15:0] pin // level seen on the pin
);
    // an undriven pin follows the board, so nothing stale is read back
    assign pin = (out & oe) | (ext & ~oe);
endmodule // pin_board

// ==== gpio_ports_checker.sv ====
// assertions on the pins and register bus of the gpio port block
`timescale 1ns/1ps
module gpio_ports_checker #(
    parameter CHANGE_COUNT = 24 // monitored inputs
) (
    input wire aclk, // clock
    input wire aresetn, // reset, low
    input wire s_axi_awvalid, // aw valid
    input wire s_axi_awready, // aw ready
    input wire s_axi_wvalid, // w valid
    input wire s_axi_wready, // w ready
    input wire s_axi_bvalid, // b valid
    input wire s_axi_arvalid, // ar valid
    input wire s_axi_arready, // ar ready
    input wire s_axi_rvalid, // r valid
    input wire [31:0] s_axi_rdata, // r data
    input wire [15:0] port_a_oe, // port a enables
    input wire [15:0] port_b_oe, // port b enables
    input wire [79:0] periph_drive, // peripheral owns pin
    input wire [23:0] pullup_en, // pull-ups
    input wire irq // interrupt
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_reset_quiet: assert property (
        $rose(aresetn) |-> port_b_oe == 16'h0 && pullup_en == 24'h0 && !irq)
        else $error("outputs not idle after reset");
    a_unimpl_off: assert property (
        (port_a_oe & 16'hf7ff) == 16'h0 && port_b_oe[15:13] == 3'h0)
        else $error("unimplemented pin driven");
    a_periph_owns: assert property ((periph_drive[31:16] & port_b_oe) == 16'h0)
        else $error("port drives a pin owned by a peripheral");
    a_pullup_mask: assert property ((pullup_en >> CHANGE_COUNT) == 24'h0)
        else $error("pull-up beyond the implemented inputs");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0)
        else $error("read answer late or upper half set");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
endmodule // gpio_ports_checker

bind gpio_ports gpio_ports_checker #(.CHANGE_COUNT(CHANGE_COUNT)) chk_u (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
    .port_a_oe, .port_b_oe, .periph_drive, .pullup_en, .irq
);

// ==== testbench.sv ====
// self-checking bench for the gpio ports with change notification
`timescale 1ns/1ps
module testbench;
    reg aclk = 1'b0;
    reg aresetn = 1'b0;
    reg [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    reg [15:0] ext_b = 16'h0, analog_b = 16'h0;
    reg [15:0] ext_a = 16'h0;
    reg [3:0] s_axi_wstrb = 4'hf;
    reg [79:0] periph_drive = '0;
    reg [23:0] change_in = 24'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [15:0] port_b_in, port_b_out, port_b_oe;
    wire [23:0] pullup_en;
    wire change_wake, irq;
    integer n_errors = 0, checks_done = 0;
    reg [9:0] ri [0:18] = '{10'h0c0, 10'h0c2, 10'h0c4, 10'h0c6, 10'h2c0, 10'h2c2, 10'h2c4,
        10'h2c6, 10'h2c8, 10'h2cb, 10'h2cc, 10'h2ce, 10'h2d0, 10'h2d2, 10'h2d4, 10'h2d6,
        10'h2de, 10'h2e0, 10'h2e2};
    reg [15:0] rv [0:18] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0800, 16'h0, 16'h0, 16'h1fff,
        16'h0, 16'h0, 16'he000, 16'h0, 16'h0, 16'h030f, 16'h0, 16'h0, 16'h007f, 16'h0, 16'h0};

    // small variant, so unimplemented change inputs are exercised
    gpio_ports #(.CHANGE_COUNT(19)) dut_u (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_a_in(ext_a), .port_a_out(),
        .port_a_oe(), .port_b_in, .port_b_out, .port_b_oe, .port_c_in(16'h0), .port_c_out(),
        .port_c_oe(), .port_d_in(16'h0), .port_d_out(), .port_d_oe(), .port_f_in(16'h0),
        .port_f_out(), .port_f_oe(), .periph_drive, .analog_b, .change_in, .pullup_en,
        .change_wake, .irq
    );
    pin_board board_u (.out(port_b_out), .oe(port_b_oe), .ext(ext_b), .pin(port_b_in));

    initial forever #5 aclk = ~aclk;

    task chk(input [33:0] got, input [33:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // readies are sampled at the falling edge; they only move on rising edges
    task bus(input w, input [9:0] i, input [15:0] d, output [31:0] q, output [1:0] r);
        integer n;
        reg ha, hw, hb;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_araddr} <= {2{20'h0, i, 2'b00}};
        s_axi_wdata <= {16'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        hb = 1'b0;
        for (n = 0; n < 40 && !hb; n = n + 1)
        begin
            @(negedge aclk);
            ha = (s_axi_awvalid && s_axi_awready) || (s_axi_arvalid && s_axi_arready);
            hw = s_axi_wvalid && s_axi_wready;
            hb = w ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready;
            r = w ? s_axi_bresp : s_axi_rresp;
            q = s_axi_rdata;
            @(posedge aclk);
            if (ha)
                {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
            if (hw)
                s_axi_wvalid <= 1'b0;
            if (hb)
                {s_axi_bready, s_axi_rready} <= 2'b00;
        end
        if (!hb)
            chk(1'b0, 1'b1);
    endtask

    task wr(input [9:0] i, input [15:0] d);
        reg [31:0] q;
        reg [1:0] r;
        bus(1'b1, i, d, q, r);
        chk(r, 2'b00);
    endtask

    task rd(input [9:0] i, input [15:0] e);
        reg [31:0] q;
        reg [1:0] r;
        bus(1'b0, i, 16'h0, q, r);
        chk({r, q}, {18'h0, e});
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_reset;
        integer k;
        reg [31:0] q;
        reg [1:0] r;
        for (k = 0; k < 19; k = k + 1)
            rd(ri[k], rv[k]);
        bus(1'b0, 10'h3ff, 16'h0, q, r);
        chk({r, q}, {2'b10, 32'h0});
        bus(1'b1, 10'h3ff, 16'hffff, q, r);
        chk(r, 2'b10);
        $display("test reset done");
    endtask

    task t_port;
        wr(10'h2c6, 16'hff00);
        @(posedge aclk);
        wr(10'h2c8, 16'hffa5);
        ext_b <= 16'h3c00;
        ext_a <= 16'hffff;
        repeat (6) @(posedge aclk);
        chk(port_b_oe, 16'h00ff);
        rd(10'h2cb, 16'h1fa5);
        rd(10'h2c8, 16'h1ca5);
        rd(10'h2c2, 16'h0800);
        analog_b <= 16'h0c00;
        periph_drive[31:16] <= 16'h000f;
        repeat (6) @(posedge aclk);
        chk(port_b_oe, 16'h00f0);
        rd(10'h2c8, 16'h10a0);
        periph_drive <= '0;
        wr(10'h2c6, 16'hffff);
        rd(10'h2c6, 16'h1fff);
        // low byte strobe only: the upper latch byte must survive
        s_axi_wstrb <= 4'h1;
        wr(10'h2cb, 16'h0000);
        s_axi_wstrb <= 4'hf;
        rd(10'h2cb, 16'h1f00);
        $display("test port done");
    endtask

    task t_change;
        wr(10'h0f1, 16'h0001);
        wr(10'h0c0, 16'h0008);
        wr(10'h0c2, 16'h00ff);
        rd(10'h0c2, 16'h0007);
        change_in <= 24'h000020;
        repeat (8) @(posedge aclk);
        chk(irq, 1'b0);
        change_in <= 24'h000028;
        #1;
        chk(change_wake, 1'b1);
        repeat (8) @(posedge aclk);
        chk(irq, 1'b1);
        // clear with the enable still set, so only the clear can drop irq
        wr(10'h0f2, 16'h0001);
        @(negedge aclk);
        chk(irq, 1'b0);
        wr(10'h0f1, 16'h0000);
        change_in <= 24'h000020;
        repeat (8) @(posedge aclk);
        chk(irq, 1'b0);
        rd(10'h0f0, 16'h0001);
        wr(10'h0f2, 16'h0001);
        change_in <= 24'h100020;
        #1;
        chk(change_wake, 1'b0);
        wr(10'h0c4, 16'hffff);
        wr(10'h0c6, 16'h00ff);
        rd(10'h0c6, 16'h0007);
        chk(pullup_en, 24'h07ffff);
        $display("test change done");
    endtask

    task stop_test;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_port;
        t_change;
        stop_test;
    end

    // whole run needs well under a thousand cycles
    initial
    begin
        #100000;
        n_errors = n_errors + 1;
        stop_test;
    end
endmodule // testbench
